// ===== src/ack_enable_bit_pkg.sv
package ack_enable_bit_pkg;
  // status codes
  localparam logic [7:0] ST_NO_INFO      = 8'hF8;
  localparam logic [7:0] ST_BUS_ERROR    = 8'h00;
  localparam logic [7:0] ST_ARB_LOST     = 8'h38;
  localparam logic [7:0] ST_ARB_LOST_SR  = 8'h68;
  localparam logic [7:0] ST_ARB_LOST_ST  = 8'hB0;
  localparam logic [7:0] ST_START_SENT   = 8'h08;
  localparam logic [7:0] ST_RSTART_SENT  = 8'h10;
  // reset values
  localparam logic [7:0] RST_ADDR        = 8'h00;
  // bit counts per frame byte
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  // bus phase
  typedef enum logic [2:0] {
    ACK_ENABLE_BIT_IDLE   = 3'b000,
    ACK_ENABLE_BIT_MADDR  = 3'b001,
    ACK_ENABLE_BIT_MDATA  = 3'b010,
    ACK_ENABLE_BIT_SADDR  = 3'b011,
    ACK_ENABLE_BIT_SDATA  = 3'b100,
    ACK_ENABLE_BIT_NAS    = 3'b101,
    ACK_ENABLE_BIT_WAITFR = 3'b110
  } ack_enable_bit_state_t;
endpackage : ack_enable_bit_pkg

// ===== src/ack_enable_bit_cond_if.sv
`timescale 1ns/100ps
// bus condition events passed from detector to controller
interface ack_enable_bit_cond_if;
  logic start_p;  // start seen
  logic stop_p;   // stop seen
  logic rise_p;   // clock rising edge
  logic fall_p;   // clock falling edge
  logic sda_s;    // synchronised data level
  logic scl_s;    // synchronised clock level
  modport src (output start_p, stop_p, rise_p, fall_p, sda_s, scl_s);
  modport dst (input start_p, stop_p, rise_p, fall_p, sda_s, scl_s);
endinterface : ack_enable_bit_cond_if

// ===== src/ack_enable_bit_cond_det.sv
`timescale 1ns/100ps
// synchronises the two bus lines and reports conditions and clock edges
module ack_enable_bit_cond_det (
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RST,
  // raw bus lines
  input  wire logic sda_in,
  input  wire logic scl_in,
  // events out
  ack_enable_bit_cond_if.src  cond
);
  logic [1:0] sda_sync_q, sda_sync_d;  // two-stage synchroniser
  logic [1:0] scl_sync_q, scl_sync_d;
  logic       sda_old_q, sda_old_d;    // previous settled level
  logic       scl_old_q, scl_old_d;

  // next values
  always_comb begin
    sda_sync_d = {sda_sync_q[0], sda_in};
    scl_sync_d = {scl_sync_q[0], scl_in};
    sda_old_d  = sda_sync_q[1];
    scl_old_d  = scl_sync_q[1];
  end

  // registers, bus idles high
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
      sda_old_q  <= 1'b1;
      scl_old_q  <= 1'b1;
    end else begin
      sda_sync_q <= sda_sync_d;
      scl_sync_q <= scl_sync_d;
      sda_old_q  <= sda_old_d;
      scl_old_q  <= scl_old_d;
    end
  end

  // data edge while clock high and steady
  assign cond.start_p = sda_old_q & ~sda_sync_q[1] & scl_sync_q[1] & scl_old_q;
  assign cond.stop_p  = ~sda_old_q & sda_sync_q[1] & scl_sync_q[1] & scl_old_q;
  assign cond.rise_p  = ~scl_old_q & scl_sync_q[1];
  assign cond.fall_p  = scl_old_q & ~scl_sync_q[1];
  assign cond.sda_s   = sda_sync_q[1];
  assign cond.scl_s   = scl_sync_q[1];
endmodule : ack_enable_bit_cond_det

// ===== src/ack_enable_bit_core.sv
`timescale 1ns/100ps
module ack_enable_bit_core (
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST,
  // bus pins
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       SCL_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE,
  // software control
  input  wire logic       START_REQUEST_FIELD,
  input  wire logic       STOP_REQUEST_SET,
  input  wire logic       FLAG_CLEAR,
  input  wire logic       ACK_ENABLE_BIT,
  input  wire logic [6:0] OWN_ADDRESS,
  input  wire logic       MASTER_BIT_VALID,
  input  wire logic       MASTER_BIT,
  // status
  output logic            TRANSFER_COMPLETE_FLAG,
  output logic            STOP_REQUEST_BIT,
  output logic [7:0]      STATUS_CODE_REGISTER,
  output logic            BUS_OWNED,
  output logic            SLAVE_RECEIVE_MODE,
  output logic            SLAVE_TRANSMIT_MODE
);
  ack_enable_bit_cond_if cond ();  // condition events

  ack_enable_bit_cond_det u_det (
    .MCLK   (MCLK),
    .RST    (RST),
    .sda_in (SDA_IN),
    .scl_in (SCL_IN),
    .cond   (cond)
  );

  ack_enable_bit_pkg::ack_enable_bit_state_t state_q, state_d;  // bus phase
  logic [3:0] bit_q, bit_d;        // bit index inside byte
  logic [7:0] shift_q, shift_d;    // serial shift data register
  logic       flag_q, flag_d;      // transfer complete flag
  logic       sto_q, sto_d;        // stop request bit
  logic [7:0] code_q, code_d;      // raw status code
  logic       sda_oe_q, sda_oe_d;  // pull data low
  logic       own_q, own_d;        // bus owned
  logic       sr_q, sr_d;          // slave receive
  logic       st_q, st_d;          // slave transmit
  logic       busy_q, busy_d;      // bus busy between start and stop
  logic       in_frame;            // inside a byte or ack bit

  // a stop or repeated start legally follows the first clock rise of a byte,
  // so only a condition after two or more rises counts as misplaced
  assign in_frame = (bit_q > 4'h1);

  // next-state logic
  always_comb begin
    state_d  = state_q;
    bit_d    = bit_q;
    shift_d  = shift_q;
    flag_d   = flag_q;
    sto_d    = sto_q | STOP_REQUEST_SET;
    code_d   = code_q;
    sda_oe_d = sda_oe_q;
    own_d    = own_q;
    sr_d     = sr_q;
    st_d     = st_q;
    busy_d   = busy_q;
    // software clear of the flag, a hardware set below wins
    if (FLAG_CLEAR) begin
      flag_d = 1'b0;
      // recovery from bus error
      if (code_q == ack_enable_bit_pkg::ST_BUS_ERROR && (sto_q | STOP_REQUEST_SET)) begin
        state_d  = ack_enable_bit_pkg::ACK_ENABLE_BIT_NAS;
        sto_d    = 1'b0;
        sda_oe_d = 1'b0;
        own_d    = 1'b0;
        sr_d     = 1'b0;
        st_d     = 1'b0;
        bit_d    = 4'h0;
        code_d   = ack_enable_bit_pkg::ST_NO_INFO;
      end
    end
    // conditions on the bus
    if (cond.start_p || cond.stop_p) begin
      busy_d = cond.start_p;
      if (in_frame) begin
        // misplaced condition
        code_d   = ack_enable_bit_pkg::ST_BUS_ERROR;
        flag_d   = 1'b1;
        sda_oe_d = 1'b0;
        bit_d    = 4'h0;
      end else if (cond.start_p) begin
        // own repeated start keeps ownership
        if (own_q) begin
          state_d = ack_enable_bit_pkg::ACK_ENABLE_BIT_MADDR;
          code_d  = ack_enable_bit_pkg::ST_RSTART_SENT;
        end else begin
          state_d = ack_enable_bit_pkg::ACK_ENABLE_BIT_SADDR;
        end
        bit_d = 4'h0;
      end else begin
        // legal stop: bus free, byte count restarts
        own_d   = 1'b0;
        sr_d    = 1'b0;
        st_d    = 1'b0;
        bit_d   = 4'h0;
        state_d = (state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_WAITFR) ? ack_enable_bit_pkg::ACK_ENABLE_BIT_WAITFR : ack_enable_bit_pkg::ACK_ENABLE_BIT_NAS;
      end
    end else if (cond.rise_p) begin
      shift_d = {shift_q[6:0], cond.sda_s};
      bit_d   = (bit_q == ack_enable_bit_pkg::BITS_PER_BYTE) ? 4'h0 : bit_q + 4'h1;
      // arbitration on address, direction and data bits
      if ((state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_MADDR || state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_MDATA)
          && bit_q != ack_enable_bit_pkg::BITS_PER_BYTE && !sda_oe_q && !cond.sda_s) begin
        own_d    = 1'b0;
        flag_d   = 1'b1;
        code_d   = ack_enable_bit_pkg::ST_ARB_LOST;
        if (state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_MADDR && bit_q < 4'h7) begin
          state_d = ack_enable_bit_pkg::ACK_ENABLE_BIT_SADDR;
        end else begin
          state_d = START_REQUEST_FIELD ? ack_enable_bit_pkg::ACK_ENABLE_BIT_WAITFR : ack_enable_bit_pkg::ACK_ENABLE_BIT_NAS;
        end
      end
      // address byte complete in slave phase
      if (state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_SADDR && bit_q == 4'h7) begin
        if (ACK_ENABLE_BIT && shift_q[6:0] == OWN_ADDRESS) begin
          sr_d    = ~cond.sda_s;
          st_d    = cond.sda_s;
          state_d = ack_enable_bit_pkg::ACK_ENABLE_BIT_SDATA;
          flag_d  = 1'b1;
          code_d  = cond.sda_s ? ack_enable_bit_pkg::ST_ARB_LOST_ST : ack_enable_bit_pkg::ST_ARB_LOST_SR;
        end else begin
          state_d = START_REQUEST_FIELD ? ack_enable_bit_pkg::ACK_ENABLE_BIT_WAITFR : ack_enable_bit_pkg::ACK_ENABLE_BIT_NAS;
        end
      end
    end else if (cond.fall_p) begin
      // master drives its next bit; identical ones never collide
      if ((state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_MADDR || state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_MDATA) && MASTER_BIT_VALID) begin
        sda_oe_d = ~MASTER_BIT;
      end else begin
        sda_oe_d = 1'b0;
      end
    end
    // wait for a free bus then begin as master
    if (state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_WAITFR && !busy_q && !cond.start_p && cond.scl_s && cond.sda_s) begin
      state_d  = ack_enable_bit_pkg::ACK_ENABLE_BIT_MADDR;
      own_d    = 1'b1;
      sda_oe_d = 1'b1;
      busy_d   = 1'b1;
      code_d   = ack_enable_bit_pkg::ST_START_SENT;
    end
    // mastership asked from idle or unaddressed slave; a pending retry is dropped when withdrawn
    if ((state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_IDLE || state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_NAS) && START_REQUEST_FIELD
        && !cond.start_p) begin
      state_d = ack_enable_bit_pkg::ACK_ENABLE_BIT_WAITFR;
    end else if (state_q == ack_enable_bit_pkg::ACK_ENABLE_BIT_WAITFR && !START_REQUEST_FIELD) begin
      state_d = ack_enable_bit_pkg::ACK_ENABLE_BIT_NAS;
    end
  end

  // state registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q  <= ack_enable_bit_pkg::ACK_ENABLE_BIT_IDLE;
      bit_q    <= 4'h0;
      shift_q  <= ack_enable_bit_pkg::RST_ADDR;
      flag_q   <= 1'b0;
      sto_q    <= 1'b0;
      code_q   <= ack_enable_bit_pkg::ST_NO_INFO;
      sda_oe_q <= 1'b0;
      own_q    <= 1'b0;
      sr_q     <= 1'b0;
      st_q     <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      bit_q    <= bit_d;
      shift_q  <= shift_d;
      flag_q   <= flag_d;
      sto_q    <= sto_d;
      code_q   <= code_d;
      sda_oe_q <= sda_oe_d;
      own_q    <= own_d;
      sr_q     <= sr_d;
      st_q     <= st_d;
      busy_q   <= busy_d;
    end
  end

  // status register shows F8 whenever the flag is clear
  logic [7:0] status_q;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      status_q <= ack_enable_bit_pkg::ST_NO_INFO;
    end else begin
      status_q <= flag_d ? code_d : ack_enable_bit_pkg::ST_NO_INFO;
    end
  end

  // outputs straight from flip-flops, except SDA_OUT, SCL_OUT and SCL_OE tied low
  assign SDA_OUT                = 1'b0;
  assign SDA_OE                 = sda_oe_q;
  assign SCL_OUT                = 1'b0;
  assign SCL_OE                 = 1'b0;
  assign TRANSFER_COMPLETE_FLAG = flag_q;
  assign STOP_REQUEST_BIT       = sto_q;
  assign STATUS_CODE_REGISTER   = status_q;
  assign BUS_OWNED              = own_q;
  assign SLAVE_RECEIVE_MODE     = sr_q;
  assign SLAVE_TRANSMIT_MODE    = st_q;
endmodule : ack_enable_bit_core

// ===== verification/ack_enable_bit_asserts.sv
`timescale 1ns/100ps
// checks status, recovery and mode outputs of the core
module ack_enable_bit_asserts (
  // clock and reset
  input wire logic       MCLK, RST,
  // bus pins
  input wire logic       SDA_IN, SDA_OUT, SDA_OE, SCL_IN, SCL_OUT, SCL_OE,
  // software control
  input wire logic       START_REQUEST_FIELD, STOP_REQUEST_SET, FLAG_CLEAR, ACK_ENABLE_BIT,
  input wire logic [6:0] OWN_ADDRESS,
  input wire logic       MASTER_BIT_VALID, MASTER_BIT,
  // status
  input wire logic       TRANSFER_COMPLETE_FLAG, STOP_REQUEST_BIT,
  input wire logic [7:0] STATUS_CODE_REGISTER,
  input wire logic       BUS_OWNED, SLAVE_RECEIVE_MODE, SLAVE_TRANSMIT_MODE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // bus error reported
  sequence s_err_seen;
    TRANSFER_COMPLETE_FLAG && STATUS_CODE_REGISTER == ack_enable_bit_pkg::ST_BUS_ERROR;
  endsequence
  // software writes stop request with flag clear
  sequence s_recover;
    s_err_seen ##0 (FLAG_CLEAR && (STOP_REQUEST_SET || STOP_REQUEST_BIT));
  endsequence
  a_recover_clear: assert property (s_recover |=> !TRANSFER_COMPLETE_FLAG && !STOP_REQUEST_BIT)
    else $error("recovery did not clear flag and stop bit");
  a_recover_release: assert property (s_recover |=> !SDA_OE [*2])
    else $error("data line driven after recovery");
  a_idle_code: assert property (!TRANSFER_COMPLETE_FLAG |-> STATUS_CODE_REGISTER == ack_enable_bit_pkg::ST_NO_INFO)
    else $error("status not F8 while flag clear");
  a_flag_stands: assert property (TRANSFER_COMPLETE_FLAG && !FLAG_CLEAR |=> TRANSFER_COMPLETE_FLAG)
    else $error("flag dropped without clear");
  a_no_line_drive: assert property (!SCL_OE && !SCL_OUT && !SDA_OUT)
    else $error("clock driven or data driven high");
  a_ack_ignore: assert property (!ACK_ENABLE_BIT |=> !$rose(SLAVE_RECEIVE_MODE) && !$rose(SLAVE_TRANSMIT_MODE))
    else $error("addressed while ack enable low");
  a_one_mode: assert property (!(SLAVE_RECEIVE_MODE && SLAVE_TRANSMIT_MODE))
    else $error("both slave modes set");
  a_stop_set: assert property (STOP_REQUEST_SET && !FLAG_CLEAR |=> STOP_REQUEST_BIT)
    else $error("stop request bit not set");
endmodule : ack_enable_bit_asserts

bind ack_enable_bit_core ack_enable_bit_asserts i_ack_enable_bit_asserts (.*);

// ===== verification/ack_enable_bit_bus_peer.sv
`timescale 1ns/100ps
// another master: makes the bus clock and pulls data low
module ack_enable_bit_bus_peer (
  // open drain drive, pull high means data low
  output logic scl,
  output logic pull
);
  // clock stands high outside frames
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end
  // data falls while clock high
  task automatic start_c();
    pull = 1'b1;
    #16 scl = 1'b0;
  endtask : start_c
  // repeated start from clock low, keeps the bus between write and read
  task automatic rstart_c();
    pull = 1'b0;
    #16 scl = 1'b1;
    #16 start_c();
  endtask : rstart_c
  // data rises while clock high
  task automatic stop_c();
    pull = 1'b1;
    #16 scl = 1'b1;
    #16 pull = 1'b0;
    #16;
  endtask : stop_c
  // one bit, msb first by caller, 32 ns
  task automatic bit_c(input logic b);
    pull = ~b;
    #16 scl = 1'b1;
    #16 scl = 1'b0;
  endtask : bit_c
endmodule : ack_enable_bit_bus_peer

// ===== verification/ack_enable_bit_core_tb.sv
`timescale 1ns/100ps
module ack_enable_bit_core_tb;
  logic       MCLK, RST, SDA_IN, SCL_IN, START_REQUEST_FIELD, STOP_REQUEST_SET, FLAG_CLEAR;
  logic       ACK_ENABLE_BIT, MASTER_BIT_VALID, MASTER_BIT, SDA_OUT, SDA_OE, SCL_OUT, SCL_OE;
  logic       TRANSFER_COMPLETE_FLAG, STOP_REQUEST_BIT, BUS_OWNED, SLAVE_RECEIVE_MODE, SLAVE_TRANSMIT_MODE;
  logic [6:0] OWN_ADDRESS;
  logic [7:0] STATUS_CODE_REGISTER;
  logic       scl_p, pull_p, flag_prev, ack;
  logic [7:0] exp_q[$];     // expected status at each flag rise
  int         err_total, n_tests, cyc, nb;
  integer     seed;
  ack_enable_bit_core i_ack_enable_bit_core (.*);
  ack_enable_bit_bus_peer i_ack_enable_bit_bus_peer (.scl(scl_p), .pull(pull_p));
  // wired lines with pull-ups
  assign SDA_IN = ~(SDA_OE | pull_p);
  assign SCL_IN = scl_p & ~SCL_OE;
  // clock
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // hang guard
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  // compares the oldest note at each flag rise
  always @(negedge MCLK) begin
    if (TRANSFER_COMPLETE_FLAG === 1'b1 && flag_prev !== 1'b1 && exp_q.size() > 0)
      chk(STATUS_CODE_REGISTER, exp_q.pop_front());
    flag_prev <= TRANSFER_COMPLETE_FLAG;
  end
  initial begin
    seed = 32'hee05a460;
    {RST, ACK_ENABLE_BIT, MASTER_BIT} = 3'b111;
    {START_REQUEST_FIELD, STOP_REQUEST_SET, FLAG_CLEAR, MASTER_BIT_VALID} = 4'h0;
    OWN_ADDRESS = 7'h2a;
    {err_total, n_tests, cyc} = '0;
    repeat (4) @(posedge MCLK);
    @(negedge MCLK) RST = 1'b0;
    chk(STATUS_CODE_REGISTER, ack_enable_bit_pkg::ST_NO_INFO);
    // misplaced stop, then misplaced start, inside a byte
    for (int k = 0; k < 2; k++) begin
      nb = 1 + int'({$random(seed)} % 7);
      exp_q.push_back(ack_enable_bit_pkg::ST_BUS_ERROR);
      i_ack_enable_bit_bus_peer.start_c();
      repeat (nb) i_ack_enable_bit_bus_peer.bit_c(1'($random(seed)));
      if (k == 0) i_ack_enable_bit_bus_peer.stop_c();
      else i_ack_enable_bit_bus_peer.rstart_c();
      repeat (4) @(negedge MCLK);
      chk({7'h00, TRANSFER_COMPLETE_FLAG}, 8'h01);
      {STOP_REQUEST_SET, FLAG_CLEAR} = 2'b11;
      @(negedge MCLK) {STOP_REQUEST_SET, FLAG_CLEAR} = 2'b00;
      chk({TRANSFER_COMPLETE_FLAG, STOP_REQUEST_BIT, SDA_OE, 5'h00}, 8'h00);
      chk(STATUS_CODE_REGISTER, ack_enable_bit_pkg::ST_NO_INFO);
      if (k == 1) i_ack_enable_bit_bus_peer.stop_c();
      $display("bus error test %0d done", k);
    end
    // address arbitration lost, own address sent by the peer
    for (int k = 0; k < 2; k++) begin
      ack = k[0];
      exp_q.push_back(ack_enable_bit_pkg::ST_ARB_LOST);
      @(negedge MCLK) {ACK_ENABLE_BIT, START_REQUEST_FIELD, MASTER_BIT_VALID} = {ack, 2'b11};
      i_ack_enable_bit_bus_peer.start_c();
      for (int i = 6; i >= 0; i--) i_ack_enable_bit_bus_peer.bit_c(OWN_ADDRESS[i]);
      i_ack_enable_bit_bus_peer.bit_c(1'b0);
      i_ack_enable_bit_bus_peer.bit_c(1'b0);
      @(negedge MCLK) START_REQUEST_FIELD = 1'b0;
      chk({5'h00, BUS_OWNED, SLAVE_RECEIVE_MODE, SLAVE_TRANSMIT_MODE}, {6'h00, ack, 1'b0});
      chk(STATUS_CODE_REGISTER, ack ? ack_enable_bit_pkg::ST_ARB_LOST_SR : ack_enable_bit_pkg::ST_ARB_LOST);
      i_ack_enable_bit_bus_peer.stop_c();
      @(negedge MCLK) {FLAG_CLEAR, MASTER_BIT_VALID} = 2'b10;
      @(negedge MCLK) FLAG_CLEAR = 1'b0;
      $display("arbitration test %0d done", k);
    end
    repeat (8) @(negedge MCLK);
    end_sim();
  end
endmodule : ack_enable_bit_core_tb
